// [rtl/pslp_pkg.sv]
// Constants for the strap and indicator pin block
package pslp_pkg;
  localparam int ADDR_W = 5;
  localparam int BIT_ACT = 0;
  localparam int BIT_COL = 1;
  localparam int BIT_LNK = 2;
  localparam int BIT_TX = 3;
  localparam int BIT_RX = 4;
  localparam int SYNC_W = 3;
  localparam logic [4:0] ADDR_RST = 5'h00;
  localparam logic [1:0] ST_RESET = 2'h0;
  localparam logic [1:0] ST_RUN = 2'h1;
  typedef enum logic [1:0] {
    PSLP_IN_RESET = 2'b00,
    PSLP_LATCH = 2'b01,
    PSLP_RUN = 2'b10
  } pslp_state_t;
endpackage : pslp_pkg

// [rtl/pslp_sync.sv]
// Three-stage synchroniser with agreement of last two stages
`timescale 1ns/1ps
`default_nettype none
module pslp_sync (
  input wire logic mclk,
  input wire logic rst,
  input wire logic async_in,
  output logic sync_out
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  always_ff @(posedge mclk) begin
    s1_r <= async_in;
    s2_r <= s1_r;
    s3_r <= s2_r;
  end
  // Change counts only once stages two and three agree
  always_ff @(posedge mclk) begin
    if (rst) begin
      sync_out <= 1'h0;
    end else if (s2_r == s3_r) begin
      sync_out <= s3_r;
    end
  end
endmodule : pslp_sync
`default_nettype wire

// [rtl/pslp_top.sv]
// Strap sampling and indicator drive on shared PHY pins
`timescale 1ns/1ps
`default_nettype none
module pslp_top (
  input wire logic mclk,
  input wire logic rst,
  input wire logic hw_reset_low_in,
  input wire logic tx_activity,
  input wire logic rx_activity,
  input wire logic any_activity,
  input wire logic collision,
  input wire logic link_up,
  input wire logic speed_100,
  input wire logic addr0_activity_pin_i,
  output logic addr0_activity_pin_o,
  output logic addr0_activity_pin_oe,
  input wire logic addr1_collision_pin_i,
  output logic addr1_collision_pin_o,
  output logic addr1_collision_pin_oe,
  input wire logic addr2_link_pin_i,
  output logic addr2_link_pin_o,
  output logic addr2_link_pin_oe,
  input wire logic addr3_tx_indicator_pin_i,
  output logic addr3_tx_indicator_pin_o,
  output logic addr3_tx_indicator_pin_oe,
  input wire logic addr4_rx_indicator_pin_i,
  output logic addr4_rx_indicator_pin_o,
  output logic addr4_rx_indicator_pin_oe,
  output logic speed_indicator_out,
  output logic [pslp_pkg::ADDR_W-1:0] phy_addr,
  output logic in_reset
);
  logic rstn_s;
  logic [pslp_pkg::ADDR_W-1:0] pin_in;
  logic [pslp_pkg::ADDR_W-1:0] pin_s;
  logic [pslp_pkg::ADDR_W-1:0] led_nxt;
  logic [pslp_pkg::ADDR_W-1:0] led_r;
  logic [pslp_pkg::ADDR_W-1:0] addr_r;
  logic oe_r;
  logic speed_r;
  pslp_pkg::pslp_state_t state_r;
  pslp_pkg::pslp_state_t state_nxt;

  // State decodes shared by the strap latch, the drivers and the status output
  function automatic logic st_holding(input pslp_pkg::pslp_state_t st);
    return st == pslp_pkg::PSLP_IN_RESET;
  endfunction : st_holding

  function automatic logic st_running(input pslp_pkg::pslp_state_t st);
    return st == pslp_pkg::PSLP_RUN;
  endfunction : st_running

  // Reset pin is asynchronous to mclk, so it is synchronised too
  pslp_sync u_rst_sync (
    .mclk(mclk),
    .rst(rst),
    .async_in(hw_reset_low_in),
    .sync_out(rstn_s)
  );

  assign pin_in = {addr4_rx_indicator_pin_i, addr3_tx_indicator_pin_i, addr2_link_pin_i,
                   addr1_collision_pin_i, addr0_activity_pin_i};

  genvar gi;
  generate
    for (gi = 0; gi < pslp_pkg::ADDR_W; gi++) begin : g_sync
      pslp_sync u_pin_sync (
        .mclk(mclk),
        .rst(rst),
        .async_in(pin_in[gi]),
        .sync_out(pin_s[gi])
      );
    end
  endgenerate

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      pslp_pkg::PSLP_IN_RESET: begin
        if (rstn_s) begin
          state_nxt = pslp_pkg::PSLP_LATCH;
        end
      end
      pslp_pkg::PSLP_LATCH: begin
        state_nxt = rstn_s ? pslp_pkg::PSLP_RUN : pslp_pkg::PSLP_IN_RESET;
      end
      pslp_pkg::PSLP_RUN: begin
        if (!rstn_s) begin
          state_nxt = pslp_pkg::PSLP_IN_RESET;
        end
      end
      default: begin
        state_nxt = pslp_pkg::PSLP_IN_RESET;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_r <= pslp_pkg::PSLP_IN_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Straps track the pins all through reset; the value at release is kept
  always_ff @(posedge mclk) begin
    if (rst) begin
      addr_r <= pslp_pkg::ADDR_RST;
    end else if (st_holding(state_r) && !rstn_s) begin
      addr_r <= pin_s;
    end
  end

  always_comb begin
    led_nxt = '0;
    led_nxt[pslp_pkg::BIT_ACT] = any_activity;
    led_nxt[pslp_pkg::BIT_COL] = collision;
    led_nxt[pslp_pkg::BIT_LNK] = link_up;
    led_nxt[pslp_pkg::BIT_TX] = tx_activity;
    led_nxt[pslp_pkg::BIT_RX] = rx_activity;
  end

  // Drivers held off one cycle past release; after reset re-entry the latch still sees our own drive until pin_s catches up
  always_ff @(posedge mclk) begin
    if (rst) begin
      oe_r <= 1'h0;
      led_r <= '0;
    end else begin
      oe_r <= st_running(state_r) && rstn_s;
      led_r <= st_running(state_r) ? led_nxt : '0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      speed_r <= 1'h0;
    end else begin
      speed_r <= speed_100;
    end
  end

  assign addr0_activity_pin_o = led_r[pslp_pkg::BIT_ACT];
  assign addr1_collision_pin_o = led_r[pslp_pkg::BIT_COL];
  assign addr2_link_pin_o = led_r[pslp_pkg::BIT_LNK];
  assign addr3_tx_indicator_pin_o = led_r[pslp_pkg::BIT_TX];
  assign addr4_rx_indicator_pin_o = led_r[pslp_pkg::BIT_RX];
  assign addr0_activity_pin_oe = oe_r;
  assign addr1_collision_pin_oe = oe_r;
  assign addr2_link_pin_oe = oe_r;
  assign addr3_tx_indicator_pin_oe = oe_r;
  assign addr4_rx_indicator_pin_oe = oe_r;
  assign speed_indicator_out = speed_r;
  assign phy_addr = addr_r;
  assign in_reset = !st_running(state_r);

  chk_strap_tx_bit: assert property (@(posedge mclk) disable iff (rst)
    (state_r == pslp_pkg::PSLP_IN_RESET && !rstn_s)
    |=> phy_addr[pslp_pkg::BIT_TX] == $past(pin_s[pslp_pkg::BIT_TX]))
    else $error("tx strap not sampled");
  chk_strap_rx_bit: assert property (@(posedge mclk) disable iff (rst)
    (state_r == pslp_pkg::PSLP_IN_RESET && !rstn_s)
    |=> phy_addr[pslp_pkg::BIT_RX] == $past(pin_s[pslp_pkg::BIT_RX]))
    else $error("rx strap not sampled");
  chk_strap_low_bits: assert property (@(posedge mclk) disable iff (rst)
    (state_r == pslp_pkg::PSLP_IN_RESET && !rstn_s)
    |=> phy_addr[pslp_pkg::BIT_LNK:pslp_pkg::BIT_ACT] == $past(pin_s[pslp_pkg::BIT_LNK:pslp_pkg::BIT_ACT]))
    else $error("low strap bits wrong");
  chk_addr_hold: assert property (@(posedge mclk) disable iff (rst)
    (state_r == pslp_pkg::PSLP_RUN)
    |=> $stable(phy_addr))
    else $error("address changed while running");
  chk_latch_keep: assert property (@(posedge mclk) disable iff (rst)
    (state_r == pslp_pkg::PSLP_LATCH)
    |=> $stable(phy_addr))
    else $error("address moved on release");
  chk_no_drive_reset: assert property (@(posedge mclk) disable iff (rst)
    (!rstn_s)
    |=> !addr3_tx_indicator_pin_oe && !addr4_rx_indicator_pin_oe)
    else $error("pin driven during reset");
  // Covers the latch cycle too, where the synced reset is already high
  chk_no_drive_hold: assert property (@(posedge mclk) disable iff (rst)
    in_reset
    |=> !(addr0_activity_pin_oe || addr1_collision_pin_oe || addr2_link_pin_oe
          || addr3_tx_indicator_pin_oe || addr4_rx_indicator_pin_oe))
    else $error("pin driven before run");
  chk_low_pins_drive: assert property (@(posedge mclk) disable iff (rst)
    (state_r == pslp_pkg::PSLP_RUN && rstn_s)
    |=> addr0_activity_pin_oe && addr1_collision_pin_oe && addr2_link_pin_oe)
    else $error("low pins not driven in run");
  chk_led_dark_hold: assert property (@(posedge mclk) disable iff (rst)
    in_reset
    |=> !addr3_tx_indicator_pin_o && !addr4_rx_indicator_pin_o)
    else $error("indicator lit outside run");
  chk_tx_led_follow: assert property (@(posedge mclk) disable iff (rst)
    (state_r == pslp_pkg::PSLP_RUN && rstn_s)
    |=> addr3_tx_indicator_pin_oe && addr3_tx_indicator_pin_o == $past(tx_activity))
    else $error("tx led wrong");
  chk_rx_led_follow: assert property (@(posedge mclk) disable iff (rst)
    (state_r == pslp_pkg::PSLP_RUN && rstn_s)
    |=> addr4_rx_indicator_pin_oe && addr4_rx_indicator_pin_o == $past(rx_activity))
    else $error("rx led wrong");
  chk_speed_follow: assert property (@(posedge mclk) disable iff (rst)
    1'h1
    |=> speed_indicator_out == $past(speed_100))
    else $error("speed output wrong");
  chk_reset_enter: assert property (@(posedge mclk) disable iff (rst)
    (!rstn_s)
    |=> in_reset)
    else $error("not in reset while reset low");
  chk_release_run: assert property (@(posedge mclk) disable iff (rst)
    (state_r == pslp_pkg::PSLP_IN_RESET && rstn_s) ##1 rstn_s
    |=> !in_reset)
    else $error("did not run after release");
endmodule : pslp_top
`default_nettype wire

// [dv/pslp_board.sv]
// Board model: strap resistors and indicator LEDs on the shared pins
`timescale 1ns/1ps
`default_nettype none
module pslp_board (
  input wire logic [4:0] strap,
  input wire logic [4:0] drv,
  input wire logic [4:0] drv_oe,
  output logic [4:0] pin
);
  // Released pin settles to its resistor level, never the last driven value
  always_comb pin = (drv_oe & drv) | (~drv_oe & strap);
endmodule : pslp_board
`default_nettype wire

// [dv/phy_strap_led_pins_tb.sv]
// Testbench for the strap and indicator pin block
`timescale 1ns/1ps
`default_nettype none
module phy_strap_led_pins_tb;
  logic mclk, rst, nrst, spd100, in_reset, spd_out;
  logic [4:0] act, strap_v, exp_a, phy_addr;
  wire [4:0] pin, o, oe;
  int fails = 0;
  int cmp_count = 0;
  pslp_board pslp_board_inst (.strap(strap_v), .drv(o), .drv_oe(oe), .pin(pin));
  pslp_top pslp_top_inst (.mclk(mclk), .rst(rst), .hw_reset_low_in(nrst),
    .tx_activity(act[3]), .rx_activity(act[4]), .any_activity(act[0]),
    .collision(act[1]), .link_up(act[2]), .speed_100(spd100),
    .addr0_activity_pin_i(pin[0]), .addr0_activity_pin_o(o[0]), .addr0_activity_pin_oe(oe[0]),
    .addr1_collision_pin_i(pin[1]), .addr1_collision_pin_o(o[1]), .addr1_collision_pin_oe(oe[1]),
    .addr2_link_pin_i(pin[2]), .addr2_link_pin_o(o[2]), .addr2_link_pin_oe(oe[2]),
    .addr3_tx_indicator_pin_i(pin[3]), .addr3_tx_indicator_pin_o(o[3]), .addr3_tx_indicator_pin_oe(oe[3]),
    .addr4_rx_indicator_pin_i(pin[4]), .addr4_rx_indicator_pin_o(o[4]), .addr4_rx_indicator_pin_oe(oe[4]),
    .speed_indicator_out(spd_out), .phy_addr(phy_addr), .in_reset(in_reset));
  // Board oscillator stands in for the system-supplied reference
  always #4 mclk = ~mclk;
  task automatic chk(input logic [4:0] got, input logic [4:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic give_verdict();
    if (fails == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict
  task automatic strap(input logic [4:0] a);
    strap_v = a;
    exp_a = a;
    nrst = 1'h0;
    repeat (8) @(posedge mclk);
    #1;
    chk(oe, 5'h00);
    chk({4'h0, in_reset}, 5'h01);
    nrst = 1'h1;
    for (int i = 0; i < 20 && in_reset !== 1'h0; i++) begin
      @(posedge mclk);
      #1;
    end
    chk({4'h0, in_reset}, 5'h00);
    chk(phy_addr, a);
    @(posedge mclk);
    #1;
    chk(oe, 5'h1F);
  endtask : strap
  // Strap pattern is flipped by LED drive; address must not follow
  task automatic check_leds();
    for (int i = 0; i < 32; i += 7) begin
      act = i[4:0];
      repeat (2) @(posedge mclk);
      #1;
      chk(pin, i[4:0]);
      chk(phy_addr, exp_a);
    end
  endtask : check_leds
  task automatic check_speed();
    for (int s = 0; s < 2; s++) begin
      spd100 = s[0];
      repeat (2) @(posedge mclk);
      #1;
      chk({4'h0, spd_out}, {4'h0, s[0]});
    end
  endtask : check_speed
  task automatic check_reenter();
    act = 5'h1F;
    nrst = 1'h0;
    for (int i = 0; i < 10 && in_reset !== 1'h1; i++) begin
      @(posedge mclk);
      #1;
    end
    chk({4'h0, in_reset}, 5'h01);
    @(posedge mclk);
    #1;
    chk(oe, 5'h00);
  endtask : check_reenter
  initial begin
    mclk = 1'h0;
    rst = 1'h1;
    nrst = 1'h0;
    spd100 = 1'h0;
    act = 5'h00;
    strap_v = 5'h15;
    exp_a = 5'h15;
    repeat (6) @(posedge mclk);
    #1 rst = 1'h0;
    strap(5'h15);
    check_leds();
    check_speed();
    check_reenter();
    strap(5'h0A);
    check_leds();
    give_verdict();
  end
  // Whole run is under a hundred cycles
  initial begin
    #20000;
    fails++;
    give_verdict();
  end
endmodule : phy_strap_led_pins_tb
`default_nettype wire
